// >>> rtl/dbuf_defs.vh
// Purpose: offsets, field positions, reset values and encodings for the split-buffer address block
// Assumes: 32-bit APB, word-aligned registers
// Notes: definitions only
`ifndef DBUF_DEFS_VH
`define DBUF_DEFS_VH

`define OFF_CONTROL      8'h00
`define OFF_SINGLE_ADDR  8'h04
`define OFF_SHARED_DATA  8'h08
`define OFF_WRITE_ADDR   8'h0c
`define OFF_READ_ADDR    8'h10
`define OFF_READ_DATA    8'h14
`define OFF_CYCLE_CMD    8'h18
`define OFF_STATUS       8'h1c

`define CTL_SPLIT_BIT    17
`define CTL_EXT_BIT      16
`define CTL_SEL_HI       7
`define CTL_SEL_LO       6
`define CTL_MASK         32'h0003_00c0
`define ADDR_MASK        32'h00ff_ffff
`define RDATA_MASK       32'h0000_ffff
`define RESET_WORD       32'h0000_0000

`define SEL_BOTH         2'b10
`define SEL_TWO_ONLY     2'b01
`define SEL_NONE         2'b00

`define INC_NONE         2'b00
`define INC_UP           2'b01
`define INC_DOWN         2'b10

`define CYCLE_LEN        4'h3

`endif

// >>> rtl/sel_map.v
// Purpose: split an address register into address pins and select lines
// Assumes: select field and extended flag come from the control register
// Notes: combinational only
`timescale 1ns/1ps
`include "dbuf_defs.vh"
module sel_map (
  input  wire [23:0] addr,
  input  wire [1:0]  sel_field,
  input  wire        ext_on,
  output reg  [23:0] pins,
  output reg         sel_one,
  output reg         sel_two,
  output reg  [23:0] sel_mask
);
  reg en_two;
  reg en_one;
  always @* begin
    en_two   = (sel_field == `SEL_BOTH) || (sel_field == `SEL_TWO_ONLY); // [R13]
    en_one   = (sel_field == `SEL_BOTH); // [R13]
    sel_mask = 24'h00_0000;
    if (ext_on) begin // [R07]
      sel_mask[23] = en_two; // [R01] [R04]
      sel_mask[22] = en_one; // [R02] [R04]
      sel_two      = en_two & addr[23];
      sel_one      = en_one & addr[22];
    end else begin // [R06]
      sel_mask[15] = en_two; // [R03] [R05]
      sel_mask[14] = en_one; // [R03] [R05]
      sel_two      = en_two & addr[15];
      sel_one      = en_one & addr[14];
    end
    pins = addr & ~sel_mask;
  end
endmodule // sel_map

// >>> rtl/addr_step.v
// Purpose: next address after a cycle, select bits held
// Assumes: mask marks bits used as selects
// Notes: carry passes through held bits unchanged
`timescale 1ns/1ps
`include "dbuf_defs.vh"
module addr_step (
  input  wire [23:0] addr,
  input  wire [23:0] sel_mask,
  input  wire [1:0]  mode,
  output reg  [23:0] next_addr
);
  reg [23:0] free_bits;
  reg [23:0] stepped;
  always @* begin
    // force held bits so the carry or borrow ripples straight over them
    free_bits = addr;
    stepped   = addr;
    if (mode == `INC_UP) begin
      free_bits = addr | sel_mask;
      stepped   = free_bits + 24'h00_0001;
    end else if (mode == `INC_DOWN) begin
      free_bits = addr & ~sel_mask;
      stepped   = free_bits - 24'h00_0001;
    end
    next_addr = (stepped & ~sel_mask) | (addr & sel_mask); // [R14]
  end
endmodule // addr_step

// >>> rtl/dbuf_port.v
// Purpose: split-buffer address and read-data registers of a parallel master port
// Assumes: APB slave, zero wait, one external cycle of fixed length
// Notes: unmapped addresses read zero and raise pslverr
`timescale 1ns/1ps
`include "dbuf_defs.vh"
// Functional notes
// [R01] write bit 23: extended select two or address
// [R02] write bit 22: extended select one or address
// [R03] write bits 15/14: selects or address bits
// [R04] read bits 23/22: extended selects or address
// [R05] read bits 15/14: selects or address bits
// [R06] extended off: field steers pins 15/14
// [R07] extended on: field steers pins 23/22
// [R08] split address registers used only in split mode
// [R09] read-data register only for split-mode reads
// [R10] single mode reads land in shared data
// [R11] address bits 31-24 read zero
// [R12] split mode uses read/write address registers
// [R13] field encodes both, two only, none
// [R14] select bits excluded from address stepping
// [R15] completed read loads bus data bits 15:0
// [R16] implemented fields clear on reset
module dbuf_port (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg  [23:0] addr_pins,
  output reg         select_line_one,
  output reg         select_line_two,
  output reg         rd_strobe,
  output reg         wr_strobe,
  output reg  [15:0] data_out,
  output reg         data_oe,
  input  wire [15:0] data_in
);
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_RUN  = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  reg  [31:0] port_control_reg_q;
  reg  [23:0] single_buffer_address_reg_q;
  reg  [31:0] shared_data_in_reg_q;
  reg  [23:0] write_target_address_q;
  reg  [23:0] read_target_address_q;
  reg  [15:0] read_input_data_q;
  reg  [1:0]  step_mode_q;
  reg  [1:0]  state_q;
  reg  [3:0]  count_q;
  reg         is_read_q;
  // read mux and error flag of the apb decode
  reg         mapped;
  reg  [31:0] read_word;
  wire [15:0] bus_data;

  wire        split_on  = port_control_reg_q[`CTL_SPLIT_BIT];
  wire        ext_on    = port_control_reg_q[`CTL_EXT_BIT];
  wire [1:0]  sel_field = port_control_reg_q[`CTL_SEL_HI:`CTL_SEL_LO];
  wire        access    = psel & penable;
  wire        wr_acc    = access & pwrite;
  wire        busy      = (state_q != ST_IDLE);
  wire        start     = wr_acc && (paddr == `OFF_CYCLE_CMD) && !busy;
  // cycle phases, named once for the pins and the registers
  wire        setup     = psel & ~penable;
  wire        in_cycle  = (state_q == ST_RUN);
  wire        cycle_end = (state_q == ST_DONE);
  wire        end_read  = cycle_end & is_read_q;
  wire        end_write = cycle_end & ~is_read_q;

  // one strobe per register keeps each register in a process of its own
  wire        we_control = wr_acc && (paddr == `OFF_CONTROL);
  wire        we_single  = wr_acc && (paddr == `OFF_SINGLE_ADDR);
  wire        we_shared  = wr_acc && (paddr == `OFF_SHARED_DATA);
  wire        we_waddr   = wr_acc && (paddr == `OFF_WRITE_ADDR);
  wire        we_raddr   = wr_acc && (paddr == `OFF_READ_ADDR);
  wire        we_rdata   = wr_acc && (paddr == `OFF_READ_DATA);

  reg  [23:0] cur_addr;
  wire [23:0] map_pins;
  wire        map_one;
  wire        map_two;
  wire [23:0] map_mask;
  wire [23:0] stepped;

  // the single-buffer address is ignored while split mode is on
  always @* begin
    if (split_on) begin // [R08] [R12]
      cur_addr = is_read_q ? read_target_address_q : write_target_address_q;
    end else begin
      cur_addr = single_buffer_address_reg_q;
    end
  end

  // the map sees the active register, so pins track a register write one clock after it lands
  sel_map u_map (
    .addr      (cur_addr),
    .sel_field (sel_field),
    .ext_on    (ext_on),
    .pins      (map_pins),
    .sel_one   (map_one),
    .sel_two   (map_two),
    .sel_mask  (map_mask)
  );

  // stepping uses the pin mask, so held select bits never drift
  addr_step u_step (
    .addr      (cur_addr),
    .sel_mask  (map_mask),
    .mode      (step_mode_q),
    .next_addr (stepped)
  );

  // three-stage capture per data pin; a bit is taken once stages two and three agree,
  // so one slow pin cannot hold back the others
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_pin_sync
      reg stage1_q;
      reg stage2_q;
      reg stage3_q;
      reg held_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage1_q <= 1'b0;
          stage2_q <= 1'b0;
          stage3_q <= 1'b0;
          held_q   <= 1'b0;
        end else begin
          stage1_q <= data_in[gi];
          stage2_q <= stage1_q;
          stage3_q <= stage2_q;
          if (stage2_q == stage3_q) begin
            held_q <= stage3_q;
          end
        end
      end
      assign bus_data[gi] = held_q;
    end
  endgenerate

  // external cycle sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ST_IDLE;
      count_q   <= 4'h0;
      is_read_q <= 1'b0;
    end else begin
      case (state_q)
        // a command that arrives while busy is dropped, never queued
        ST_IDLE: begin
          if (start) begin
            state_q   <= ST_RUN;
            count_q   <= `CYCLE_LEN;
            is_read_q <= pwdata[0];
          end
        end
        // count runs from the cycle length down to one, then one cycle to finish
        ST_RUN: begin
          if (count_q == 4'h1) begin
            state_q <= ST_DONE;
          end
          count_q <= count_q - 4'h1;
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // address and data pins follow the active register at all times
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_pins <= 24'h00_0000;
      data_out  <= 16'h0000;
    end else begin
      addr_pins <= map_pins; // [R06] [R07]
      data_out  <= shared_data_in_reg_q[15:0];
    end
  end

  // selects and strobes share one timing, so a select never shows without a strobe
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_line_one <= 1'b0;
      select_line_two <= 1'b0;
      rd_strobe       <= 1'b0;
      wr_strobe       <= 1'b0;
      data_oe         <= 1'b0;
    end else begin
      select_line_one <= in_cycle & map_one;
      select_line_two <= in_cycle & map_two;
      rd_strobe       <= in_cycle & is_read_q;
      wr_strobe       <= in_cycle & ~is_read_q;
      data_oe         <= in_cycle & ~is_read_q;
    end
  end

  // control word and step mode; undefined control bits are dropped on write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_control_reg_q <= `RESET_WORD;
      step_mode_q        <= `INC_NONE;
    end else if (we_control) begin
      port_control_reg_q <= pwdata & `CTL_MASK;
      step_mode_q        <= pwdata[12:11];
    end
  end

  // in each register below a cycle completion wins over a software write in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_buffer_address_reg_q <= 24'h00_0000;
    end else if (cycle_end && !split_on) begin
      single_buffer_address_reg_q <= stepped; // [R14]
    end else if (we_single) begin
      single_buffer_address_reg_q <= pwdata[23:0];
    end
  end

  // single mode reads land here, zero-extended
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_data_in_reg_q <= `RESET_WORD;
    end else if (end_read && !split_on) begin
      shared_data_in_reg_q <= {16'h0000, bus_data}; // [R10]
    end else if (we_shared) begin
      shared_data_in_reg_q <= pwdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_target_address_q <= 24'h00_0000; // [R16]
    end else if (end_write && split_on) begin
      write_target_address_q <= stepped; // [R12] [R14]
    end else if (we_waddr) begin
      write_target_address_q <= pwdata[23:0]; // [R01] [R02] [R03]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_target_address_q <= 24'h00_0000; // [R16]
    end else if (end_read && split_on) begin
      read_target_address_q <= stepped; // [R12] [R14]
    end else if (we_raddr) begin
      read_target_address_q <= pwdata[23:0]; // [R04] [R05]
    end
  end

  // read data fills only from split-mode reads; upper half is unimplemented
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_input_data_q <= 16'h0000; // [R16]
    end else if (end_read && split_on) begin
      read_input_data_q <= bus_data; // [R09] [R15]
    end else if (we_rdata) begin
      read_input_data_q <= pwdata[15:0];
    end
  end

  // one decode feeds both the read mux and the error flag
  always @* begin
    mapped    = 1'b1;
    read_word = 32'h0000_0000;
    case (paddr)
      `OFF_CONTROL:     read_word = port_control_reg_q | {19'h0, step_mode_q, 11'h0};
      `OFF_SINGLE_ADDR: read_word = {8'h00, single_buffer_address_reg_q};
      `OFF_SHARED_DATA: read_word = shared_data_in_reg_q;
      `OFF_WRITE_ADDR:  read_word = {8'h00, write_target_address_q}; // [R11]
      `OFF_READ_ADDR:   read_word = {8'h00, read_target_address_q}; // [R11]
      `OFF_READ_DATA:   read_word = {16'h0000, read_input_data_q};
      `OFF_CYCLE_CMD:   read_word = 32'h0000_0000;
      `OFF_STATUS:      read_word = {31'h0, busy};
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // apb answer, zero wait: decided in the setup cycle, shown for the one access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite) ? read_word : 32'h0000_0000;
    end
  end
endmodule // dbuf_port

// >>> dv/dbuf_port_chk.sv
// Purpose: protocol and mapping checks on the split-buffer port
// Assumes: control register at offset 0x00, tracked from apb writes
// Notes: bound to dbuf_port below
`timescale 1ns/1ps
module dbuf_port_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire [23:0] addr_pins,
  input wire        select_line_one,
  input wire        select_line_two,
  input wire        rd_strobe,
  input wire        wr_strobe,
  input wire        data_oe
);
  reg [31:0] ctl_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_q <= 32'h0000_0000;
    else if (psel && penable && pwrite && paddr == 8'h00) ctl_q <= pwdata;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // two samples so registered pins have caught up with a new setting
  sequence s_base_both; (ctl_q[7:6] == 2'b10 && !ctl_q[16]) [*2]; endsequence
  sequence s_ext_both; (ctl_q[7:6] == 2'b10 && ctl_q[16]) [*2]; endsequence
  sequence s_rd_pulse; rd_strobe [*3] ##1 !rd_strobe; endsequence
  a_base_pins: assert property (s_base_both |-> addr_pins[15:14] == 2'b00)
    else $error("pins 15/14 not freed for selects");
  a_ext_pins: assert property (s_ext_both |-> addr_pins[23:22] == 2'b00)
    else $error("pins 23/22 not freed for selects");
  a_one_gate: assert property (select_line_one |-> ctl_q[7:6] == 2'b10)
    else $error("select one active without both enabled");
  a_two_gate: assert property (select_line_two |-> ctl_q[7:6] inside {2'b10, 2'b01})
    else $error("select two active while disabled");
  a_sel_cycle: assert property ((select_line_one || select_line_two) |-> (rd_strobe || wr_strobe))
    else $error("select active outside a cycle");
  a_rd_len: assert property ($rose(rd_strobe) |-> s_rd_pulse)
    else $error("read strobe length wrong");
  a_rd_nodrive: assert property (rd_strobe |-> !data_oe && !wr_strobe)
    else $error("bus driven during read");
  a_hi_zero: assert property (pready && !pwrite && (paddr == 8'h0c || paddr == 8'h10) |-> prdata[31:24] == 8'h00)
    else $error("address upper byte not zero");
  a_rdata_hi: assert property (pready && !pwrite && paddr == 8'h14 |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_reset_idle: assert property ($rose(presetn) |-> !select_line_one && !select_line_two && addr_pins == 24'h0)
    else $error("outputs not idle after reset");
endmodule // dbuf_port_chk
bind dbuf_port dbuf_port_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .addr_pins(addr_pins),
  .select_line_one(select_line_one), .select_line_two(select_line_two), .rd_strobe(rd_strobe),
  .wr_strobe(wr_strobe), .data_oe(data_oe));

// >>> dv/ext_mem_model.sv
// Purpose: one-word external memory on the parallel bus
// Assumes: strobes and selects active high
// Notes: records pins and selects seen during the last cycle
`timescale 1ns/1ps
module ext_mem_model (
  input  wire        pclk,
  input  wire        rd_strobe,
  input  wire        wr_strobe,
  input  wire        select_line_one,
  input  wire        select_line_two,
  input  wire [23:0] addr_pins,
  input  wire [15:0] data_out,
  output wire [15:0] data_in,
  output reg  [23:0] seen_addr,
  output reg  [1:0]  seen_sel
);
  reg [15:0] word_q = 16'hc33c;
  // held steadily: the port needs data settled well before cycle end
  assign data_in = word_q;
  always @(posedge pclk) begin
    if (wr_strobe) word_q <= data_out;
    if (rd_strobe || wr_strobe) begin
      seen_addr <= addr_pins;
      seen_sel  <= {select_line_two, select_line_one};
    end
  end
endmodule // ext_mem_model

// >>> dv/test_dbuf_port.sv
// Purpose: self-checking bench for the split-buffer port
// Assumes: zero-wait apb slave, one-word partner memory
// Notes: one task per scenario
`timescale 1ns/1ps
`include "dbuf_defs.vh"
module test_dbuf_port;
  reg         pclk, presetn, psel, penable, pwrite, err_q;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready, pslverr, select_line_one, select_line_two, rd_strobe, wr_strobe, data_oe;
  wire [23:0] addr_pins, seen_addr;
  wire [15:0] data_out, data_in;
  wire [1:0]  seen_sel;
  integer     err_total, checked;
  dbuf_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .addr_pins(addr_pins),
    .select_line_one(select_line_one), .select_line_two(select_line_two), .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe), .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  ext_mem_model mem (.pclk(pclk), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .select_line_one(select_line_one),
    .select_line_two(select_line_two), .addr_pins(addr_pins), .data_out(data_out), .data_in(data_in),
    .seen_addr(seen_addr), .seen_sel(seen_sel));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task print_verdict;
    begin
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d, output [31:0] r);
    begin
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    reg [31:0] r;
    begin
      apb(1'b0, a, 32'h0, r);
      chk(r, e);
    end
  endtask
  task cyc(input [31:0] k);
    reg [31:0] s;
    integer n;
    begin
      wr(`OFF_CYCLE_CMD, k);
      s = 32'h1;
      n = 0;
      while (s[0] !== 1'b0 && n < 20) begin
        apb(1'b0, `OFF_STATUS, 32'h0, s);
        n = n + 1;
      end
      chk({31'h0, s[0]}, 32'h0);
    end
  endtask
  task t_reset_vals;
    reg [31:0] r;
    begin
      rd(`OFF_WRITE_ADDR, 32'h0);
      rd(`OFF_READ_ADDR, 32'h0);
      rd(`OFF_READ_DATA, 32'h0);
      apb(1'b0, 8'h40, 32'h0, r);
      chk({err_q, r[30:0]}, 32'h8000_0000);
    end
  endtask
  task t_hi_bits;
    begin
      wr(`OFF_WRITE_ADDR, 32'hffff_ffff);
      rd(`OFF_WRITE_ADDR, 32'h00ff_ffff);
      wr(`OFF_READ_ADDR, 32'hffff_ffff);
      rd(`OFF_READ_ADDR, 32'h00ff_ffff);
    end
  endtask
  task t_split_write;
    begin
      wr(`OFF_CONTROL, 32'h0003_0080);
      wr(`OFF_WRITE_ADDR, 32'h00c0_c001);
      wr(`OFF_SHARED_DATA, 32'h0000_a5c3);
      cyc(32'h0);
      chk({8'h0, seen_addr}, 32'h0000_c001);
      chk({30'h0, seen_sel}, 32'h3);
      wr(`OFF_CONTROL, 32'h0002_0080);
      wr(`OFF_WRITE_ADDR, 32'h0012_c034);
      cyc(32'h0);
      chk({8'h0, seen_addr}, 32'h0012_0034);
      chk({30'h0, seen_sel}, 32'h3);
    end
  endtask
  task t_split_read;
    begin
      wr(`OFF_CONTROL, 32'h0003_0040);
      wr(`OFF_READ_ADDR, 32'h00c0_4321);
      cyc(32'h1);
      chk({8'h0, seen_addr}, 32'h0040_4321);
      chk({30'h0, seen_sel}, 32'h2);
      rd(`OFF_READ_DATA, 32'h0000_a5c3);
    end
  endtask
  task t_single_read;
    begin
      wr(`OFF_CONTROL, 32'h0002_0000);
      wr(`OFF_SHARED_DATA, 32'h0000_0ff0);
      cyc(32'h0);
      chk({8'h0, seen_addr}, 32'h0012_c034);
      wr(`OFF_SHARED_DATA, 32'h0000_1234);
      wr(`OFF_CONTROL, 32'h0);
      wr(`OFF_SINGLE_ADDR, 32'h0000_0777);
      cyc(32'h1);
      chk({8'h0, seen_addr}, 32'h0000_0777);
      rd(`OFF_SHARED_DATA, 32'h0000_0ff0);
      rd(`OFF_READ_DATA, 32'h0000_a5c3);
    end
  endtask
  task t_step;
    begin
      wr(`OFF_CONTROL, 32'h0002_0880);
      wr(`OFF_WRITE_ADDR, 32'h0000_ffff);
      cyc(32'h0);
      rd(`OFF_WRITE_ADDR, 32'h0001_c000);
    end
  endtask
  task t_mid_reset;
    begin
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(`OFF_WRITE_ADDR, 32'h0);
      rd(`OFF_READ_ADDR, 32'h0);
      rd(`OFF_READ_DATA, 32'h0);
    end
  endtask
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    err_total = 0; checked = 0; err_q = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_vals;
    t_hi_bits;
    t_split_write;
    t_split_read;
    t_single_read;
    t_step;
    t_mid_reset;
    print_verdict;
  end
  initial begin
    #200000;
    err_total = err_total + 1;
    print_verdict;
  end
endmodule // test_dbuf_port
